// *** servo_aux_pkg.sv ***
// Package for the servo auxiliary loop logic: register map, field positions,
// reset values, modes and timing constants.
// Assumes a 32-bit AXI4-Lite register bus and a 250 MHz control clock.
package servo_aux_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_FUNC     = 8'h04;
  localparam logic [7:0] OFF_ISTOP_TL = 8'h08;
  localparam logic [7:0] OFF_G3_TIME  = 8'h0C;
  localparam logic [7:0] OFF_G3_RATIO = 8'h10;
  localparam logic [7:0] OFF_PG_TIME  = 8'h14;
  localparam logic [7:0] OFF_UNBAL    = 8'h18;
  localparam logic [7:0] OFF_FWD_FRIC = 8'h1C;
  localparam logic [7:0] OFF_REV_FRIC = 8'h20;
  localparam logic [7:0] OFF_STATUS   = 8'h24;

  // Field positions
  localparam int CTRL_STOP_LSB   = 0;
  localparam int FUNC_DOB_EN     = 1;
  localparam int FUNC_DOB_G1ONLY = 2;
  localparam int ST_FWD_BLK  = 0;
  localparam int ST_REV_BLK  = 1;
  localparam int ST_DOB_ON   = 2;
  localparam int ST_ERR_CLR  = 3;
  localparam int ST_DBRAKE   = 4;
  localparam int ST_LOCK     = 5;
  localparam int ST_GSEL_LSB = 6;

  // Reset values
  localparam logic [1:0]  RST_STOP = 2'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Cycles per millisecond tick of the gain timers: 1 ms at 4 ns
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TICK_TIME_PS  = 1000000000;
  localparam int TICK_CYCLES   = TICK_TIME_PS / CLK_PERIOD_PS;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {CM_POS, CM_SPEED, CM_TORQUE, CM_FULL} ctrl_mode_e;
  typedef enum logic [1:0] {GAIN1, GAIN2, GAIN3} gain_sel_e;
  typedef enum logic [1:0] {LS_RUN, LS_DECEL, LS_STOPPED} limit_st_e;

  typedef struct packed {
    logic        fwd_cmd;
    logic        rev_cmd;
    logic        speed_zero;
  } motion_s;

  typedef struct packed {
    logic [15:0] pos_gain;
    logic [15:0] spd_gain;
  } gains_s;

endpackage

// *** servo_loop_aux_functions.sv ***
// Auxiliary loop logic of a servo drive: limit-switch stop sequence,
// disturbance observer qualification, gain 3 stage and torque offsets.
// Assumes the host drives AXI4-Lite on aclk; limit inputs come from pins.
// How it works
// - Stop 0 brakes dynamically, stop 1 free-runs; blocked torque zero, error held.
// - Stop 2 stops immediately, then servo-locks; error counter cleared before and after.
// - Limit input off blocks that direction only, the other stays allowed.
// - Stop 2 clamps deceleration torque to the immediate-stop limit.
// - Observer needs position/speed mode, servo on, normal, no autotune, no speed observer.
// - Function bit 1 enables the disturbance observer.
// - Function bit 2 set restricts observer to gain 1; clear runs it always.
// - Position or fully-closed mode with servo on inserts gain 3 before stopping.
// - Gain 3 lasts the effective time; value is gain 1 times ratio.
// - Gain 3 replaces only position and speed gains; others stay gain 1.
// - Gain 2 condition during gain 3 switches to gain 2.
// - Gain 2 to gain 3 ramps position gain over switching time.
// - Gain 2 to gain 1 by parameter change still yields gain 3 region.
// - Unbalanced offset added in every mode except torque control.
// - Position modes add forward or reverse friction by command direction.
// - Torque control forces both compensations to zero.
// - Speed mode servo off keeps unbalanced offset, friction zero.
// - Servo on in position modes holds offsets until first command.
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module servo_loop_aux_functions
#(
  parameter int TICK = servo_aux_pkg::TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Limit switch pins, high when the axis is free
  input  wire logic                    fwd_limit_input,
  input  wire logic                    rev_limit_input,
  // Loop context from the drive
  input  wire servo_aux_pkg::ctrl_mode_e ctrl_mode,
  input  wire logic                    servo_on,
  input  wire logic                    motor_normal,
  input  wire logic                    autotune_on,
  input  wire logic                    speed_observer_on,
  input  wire logic                    gain2_cond,
  input  wire servo_aux_pkg::motion_s  motion,
  input  wire servo_aux_pkg::gains_s   gain1,
  input  wire logic signed [15:0]      torque_in,
  // Results
  output logic signed [15:0]           torque_out,
  output servo_aux_pkg::gains_s        gain_out,
  output logic                         dob_active,
  output logic                         err_clear,
  output logic                         dyn_brake,
  output logic                         servo_lock
);

  initial
  begin
    if (TICK < 1)
      $error("TICK must be at least one cycle");
  end

  typedef struct packed {
    logic        aw_h;
    logic        w_h;
    logic [7:0]  awa;
    logic [31:0] wd;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [1:0]  stop_sel;
    logic [2:0]  func;
    logic [15:0] istop_tl;
    logic [15:0] g3_time;
    logic [15:0] g3_ratio;
    logic [15:0] pg_time;
    logic signed [15:0] unbal;
    logic signed [15:0] ffric;
    logic signed [15:0] rfric;
    logic [2:0]  fsync;
    logic [2:0]  rsync;
    logic        fwd_ok;
    logic        rev_ok;
    servo_aux_pkg::limit_st_e lst;
    servo_aux_pkg::gain_sel_e gsel;
    logic        cmd_prev;
    logic [31:0] tick_cnt;
    logic [15:0] g3_left;
    logic [15:0] ramp_left;
    logic        held;
    logic signed [15:0] comp_unbal;
    logic signed [15:0] comp_fric;
    logic        servo_prev;
    logic signed [15:0] tq;
    servo_aux_pkg::gains_s gains;
    logic        dob;
    logic        eclr;
    logic        dbrk;
    logic        lock;
  } state_s;

  state_s st;
  state_s next_st;

  logic        cmd_now;
  logic        pos_mode;
  logic        fwd_blk;
  logic        rev_blk;
  logic [31:0] g3_pos;
  logic [31:0] g3_spd;
  logic signed [17:0] tsum;
  logic signed [15:0] tlim;
  logic [7:0]  wa;
  logic        do_wr;

  assign cmd_now  = motion.fwd_cmd | motion.rev_cmd;
  assign pos_mode = (ctrl_mode == servo_aux_pkg::CM_POS) || (ctrl_mode == servo_aux_pkg::CM_FULL);
  assign fwd_blk  = !st.fwd_ok;
  assign rev_blk  = !st.rev_ok;
  // Gain 3 value is gain 1 scaled by a percentage ratio
  assign g3_pos   = (32'(gain1.pos_gain) * 32'(st.g3_ratio)) / 32'd100;
  assign g3_spd   = (32'(gain1.spd_gain) * 32'(st.g3_ratio)) / 32'd100;
  assign wa       = st.aw_h ? st.awa : s_axi_awaddr;
  assign do_wr    = (st.aw_h || s_axi_awvalid) && (st.w_h || s_axi_wvalid) && !st.bvalid;

  // All next-state logic in one process
  always_comb
  begin
    next_st = st;
    // Write channels taken in either order, held until both arrive
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_st.aw_h = 1'b1;
      next_st.awa  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_st.w_h = 1'b1;
      next_st.wd  = s_axi_wdata;
    end
    if (do_wr)
    begin
      next_st.aw_h   = 1'b0;
      next_st.w_h    = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = servo_aux_pkg::RESP_OKAY;
      case (wa)
        servo_aux_pkg::OFF_CTRL:     next_st.stop_sel = (st.w_h ? st.wd[1:0] : s_axi_wdata[1:0]);
        servo_aux_pkg::OFF_FUNC:     next_st.func     = (st.w_h ? st.wd[2:0] : s_axi_wdata[2:0]);
        servo_aux_pkg::OFF_ISTOP_TL: next_st.istop_tl = (st.w_h ? st.wd[15:0] : s_axi_wdata[15:0]);
        servo_aux_pkg::OFF_G3_TIME:  next_st.g3_time  = (st.w_h ? st.wd[15:0] : s_axi_wdata[15:0]);
        servo_aux_pkg::OFF_G3_RATIO: next_st.g3_ratio = (st.w_h ? st.wd[15:0] : s_axi_wdata[15:0]);
        servo_aux_pkg::OFF_PG_TIME:  next_st.pg_time  = (st.w_h ? st.wd[15:0] : s_axi_wdata[15:0]);
        servo_aux_pkg::OFF_UNBAL:    next_st.unbal    = (st.w_h ? st.wd[15:0] : s_axi_wdata[15:0]);
        servo_aux_pkg::OFF_FWD_FRIC: next_st.ffric    = (st.w_h ? st.wd[15:0] : s_axi_wdata[15:0]);
        servo_aux_pkg::OFF_REV_FRIC: next_st.rfric    = (st.w_h ? st.wd[15:0] : s_axi_wdata[15:0]);
        default:                     next_st.bresp    = servo_aux_pkg::RESP_SLVERR;
      endcase
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    // Read: one cycle after address
    if (s_axi_arvalid && !st.rvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = servo_aux_pkg::RESP_OKAY;
      case (s_axi_araddr)
        servo_aux_pkg::OFF_CTRL:     next_st.rdata = {30'h0, st.stop_sel};
        servo_aux_pkg::OFF_FUNC:     next_st.rdata = {29'h0, st.func};
        servo_aux_pkg::OFF_ISTOP_TL: next_st.rdata = {16'h0, st.istop_tl};
        servo_aux_pkg::OFF_G3_TIME:  next_st.rdata = {16'h0, st.g3_time};
        servo_aux_pkg::OFF_G3_RATIO: next_st.rdata = {16'h0, st.g3_ratio};
        servo_aux_pkg::OFF_PG_TIME:  next_st.rdata = {16'h0, st.pg_time};
        servo_aux_pkg::OFF_UNBAL:    next_st.rdata = {16'h0, st.unbal};
        servo_aux_pkg::OFF_FWD_FRIC: next_st.rdata = {16'h0, st.ffric};
        servo_aux_pkg::OFF_REV_FRIC: next_st.rdata = {16'h0, st.rfric};
        servo_aux_pkg::OFF_STATUS:   next_st.rdata = {24'h0, st.gsel, st.lock, st.dbrk, st.eclr, st.dob,
                                                      rev_blk, fwd_blk};
        default:
        begin
          next_st.rdata = servo_aux_pkg::RST_WORD;
          next_st.rresp = servo_aux_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;

    // Limit pins: three flops, change accepted when last two agree
    next_st.fsync = {st.fsync[1:0], fwd_limit_input};
    next_st.rsync = {st.rsync[1:0], rev_limit_input};
    if (st.fsync[2] == st.fsync[1])
      next_st.fwd_ok = st.fsync[2];
    if (st.rsync[2] == st.rsync[1])
      next_st.rev_ok = st.rsync[2];

    // Stop sequence on a blocked direction being commanded
    next_st.eclr = 1'b0;
    case (st.lst)
      servo_aux_pkg::LS_RUN:
        if ((fwd_blk && motion.fwd_cmd) || (rev_blk && motion.rev_cmd))
        begin
          next_st.lst  = servo_aux_pkg::LS_DECEL;
          next_st.eclr = (st.stop_sel == 2'h2);
        end
      servo_aux_pkg::LS_DECEL:
        if (motion.speed_zero)
        begin
          next_st.lst  = servo_aux_pkg::LS_STOPPED;
          next_st.eclr = (st.stop_sel == 2'h2);
        end
      servo_aux_pkg::LS_STOPPED:
        if (!fwd_blk && !rev_blk)
          next_st.lst = servo_aux_pkg::LS_RUN;
      default:
        next_st.lst = servo_aux_pkg::LS_RUN;
    endcase
    // Dynamic brake only while decelerating with selection 0
    next_st.dbrk = (next_st.lst == servo_aux_pkg::LS_DECEL) && (st.stop_sel == 2'h0);
    next_st.lock = (next_st.lst == servo_aux_pkg::LS_STOPPED) && (st.stop_sel == 2'h2);

    // Gain selection with gain 3 stage before stopping
    next_st.cmd_prev = cmd_now;
    next_st.tick_cnt = (st.tick_cnt >= 32'(TICK - 1)) ? 32'h0 : st.tick_cnt + 32'h1;
    if (st.ramp_left != 16'h0 && st.tick_cnt == 32'h0)
      next_st.ramp_left = st.ramp_left - 16'h1;
    if (!pos_mode || !servo_on || !motor_normal)
      next_st.gsel = gain2_cond ? servo_aux_pkg::GAIN2 : servo_aux_pkg::GAIN1;
    else if (gain2_cond)
      next_st.gsel = servo_aux_pkg::GAIN2;
    else if (st.gsel == servo_aux_pkg::GAIN2 || (st.cmd_prev && !cmd_now))
    begin
      // Leaving gain 2 or command end opens the gain 3 region
      next_st.gsel    = (st.g3_time != 16'h0) ? servo_aux_pkg::GAIN3 : servo_aux_pkg::GAIN1;
      next_st.g3_left = st.g3_time;
      if (st.gsel == servo_aux_pkg::GAIN2)
        next_st.ramp_left = st.pg_time;
    end
    else if (st.gsel == servo_aux_pkg::GAIN3)
    begin
      if (st.tick_cnt == 32'h0)
        next_st.g3_left = st.g3_left - 16'h1;
      if (st.g3_left == 16'h0 || cmd_now)
        next_st.gsel = servo_aux_pkg::GAIN1;
    end

    // Only position and speed gains take gain 3, others stay gain 1 outside
    if (st.gsel == servo_aux_pkg::GAIN3)
    begin
      next_st.gains.spd_gain = g3_spd[15:0];
      if (st.ramp_left != 16'h0 && st.pg_time != 16'h0)
        next_st.gains.pos_gain = 16'((32'(gain1.pos_gain) * 32'(st.ramp_left)
                                 + g3_pos * 32'(st.pg_time - st.ramp_left)) / 32'(st.pg_time));
      else
        next_st.gains.pos_gain = g3_pos[15:0];
    end
    else
      next_st.gains = gain1;

    // Disturbance observer qualification
    next_st.dob = (ctrl_mode == servo_aux_pkg::CM_POS || ctrl_mode == servo_aux_pkg::CM_SPEED)
                  && servo_on && motor_normal && !autotune_on && !speed_observer_on
                  && st.func[servo_aux_pkg::FUNC_DOB_EN]
                  && (!st.func[servo_aux_pkg::FUNC_DOB_G1ONLY] || st.gsel == servo_aux_pkg::GAIN1);

    // Torque offsets
    next_st.servo_prev = servo_on;
    if (ctrl_mode == servo_aux_pkg::CM_TORQUE)
    begin
      next_st.comp_unbal = 16'sh0;
      next_st.comp_fric  = 16'sh0;
      next_st.held       = 1'b0;
    end
    else if (ctrl_mode == servo_aux_pkg::CM_SPEED)
    begin
      next_st.comp_unbal = st.unbal;
      next_st.comp_fric  = 16'sh0;
      next_st.held       = 1'b0;
    end
    else
    begin
      if (servo_on && !st.servo_prev)
        next_st.held = 1'b1;
      if (!(st.held || (servo_on && !st.servo_prev)) || cmd_now)
      begin
        next_st.held       = 1'b0;
        next_st.comp_unbal = st.unbal;
        if (motion.fwd_cmd)
          next_st.comp_fric = st.ffric;
        else if (motion.rev_cmd)
          next_st.comp_fric = st.rfric;
      end
    end

    // Torque: sum, then block prohibited direction, clamp in immediate stop
    tsum = 18'(torque_in) + 18'(st.comp_unbal) + 18'(st.comp_fric);
    if (tsum > 18'sd32767)
      tlim = 16'sh7FFF;
    else if (tsum < -18'sd32768)
      tlim = -16'sh8000;
    else
      tlim = tsum[15:0];
    if (fwd_blk && tlim > 16'sh0)
      tlim = 16'sh0;
    if (rev_blk && tlim < 16'sh0)
      tlim = 16'sh0;
    if (st.lst == servo_aux_pkg::LS_DECEL && st.stop_sel == 2'h2)
    begin
      if (tlim > $signed({1'b0, st.istop_tl[14:0]}))
        tlim = $signed({1'b0, st.istop_tl[14:0]});
      if (tlim < -$signed({1'b0, st.istop_tl[14:0]}))
        tlim = -$signed({1'b0, st.istop_tl[14:0]});
    end
    else if (st.lst == servo_aux_pkg::LS_DECEL)
      tlim = 16'sh0;
    next_st.tq = tlim;
  end

  // State register, synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st          <= '0;
      st.stop_sel <= servo_aux_pkg::RST_STOP;
      st.fwd_ok   <= 1'b1;
      st.rev_ok   <= 1'b1;
      st.fsync    <= 3'h7;
      st.rsync    <= 3'h7;
    end
    else
      st <= next_st;
  end

  // Outputs straight from state; ready held low while a response is pending
  assign s_axi_awready = !st.aw_h && !st.bvalid;
  assign s_axi_wready  = !st.w_h && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rresp   = st.rresp;
  assign s_axi_rdata   = st.rdata;
  assign torque_out    = st.tq;
  assign gain_out      = st.gains;
  assign dob_active    = st.dob;
  assign err_clear     = st.eclr;
  assign dyn_brake     = st.dbrk;
  assign servo_lock    = st.lock;

  a_dob_needs_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    dob_active |-> $past(st.func[servo_aux_pkg::FUNC_DOB_EN]))
    else $error("observer active while disabled");
  a_dob_torque_off: assert property (@(posedge aclk) disable iff (!aresetn)
    dob_active |-> $past(ctrl_mode) != servo_aux_pkg::CM_TORQUE && $past(servo_on))
    else $error("observer active out of mode");
  a_dob_gain1_only: assert property (@(posedge aclk) disable iff (!aresetn)
    (dob_active && $past(st.func[servo_aux_pkg::FUNC_DOB_G1ONLY])) |-> $past(st.gsel) == servo_aux_pkg::GAIN1)
    else $error("observer active outside gain 1");
  // The mode seen now decides the compensation registered at this edge
  a_torque_comp_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_mode == servo_aux_pkg::CM_TORQUE) |=> st.comp_unbal == 16'sh0 && st.comp_fric == 16'sh0)
    else $error("compensation in torque mode");
  a_speed_fric_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_mode == servo_aux_pkg::CM_SPEED) |=> st.comp_fric == 16'sh0 && st.comp_unbal == $past(st.unbal))
    else $error("speed mode compensation wrong");
  a_fwd_block_torque: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(fwd_blk) && $past(st.lst) != servo_aux_pkg::LS_DECEL) |-> torque_out <= 16'sh0)
    else $error("forward torque while blocked");
  a_brake_only_sel0: assert property (@(posedge aclk) disable iff (!aresetn)
    dyn_brake |-> st.lst == servo_aux_pkg::LS_DECEL && $past(st.stop_sel) == 2'h0)
    else $error("brake in wrong mode");
  a_gain2_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    (gain2_cond && st.gsel == servo_aux_pkg::GAIN3) |=> st.gsel == servo_aux_pkg::GAIN2)
    else $error("gain 3 kept under gain 2 condition");

  // Entering the stop sequence under selection 2 must clear the error counter
  sequence s_decel_entry_sel2;
    (st.lst == servo_aux_pkg::LS_RUN && st.stop_sel == 2'h2) ##1 st.lst == servo_aux_pkg::LS_DECEL;
  endsequence
  a_clear_decel_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    s_decel_entry_sel2 |-> err_clear)
    else $error("error counter not cleared on stop entry");

endmodule

// *** axis_model.sv ***
// Far-side model: the axis limit switches and the host's position commands.
// Assumes the bench sets the wanted command direction and switch levels.
`timescale 1ns/1ps
module axis_model
#(
  parameter int SETTLE = 12
)
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Bench controls: bit 0 forward, bit 1 reverse
  input  wire logic [1:0]        cmd,
  input  wire logic [1:0]        free,
  // Toward the block
  output logic                   fwd_limit_input,
  output logic                   rev_limit_input,
  output servo_aux_pkg::motion_s motion
);
  logic [7:0] idle;
  // Switch contacts are high while the axis is free
  assign fwd_limit_input = free[0];
  assign rev_limit_input = free[1];
  // A command into an open switch moves nothing, so the axis coasts to rest
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (cmd[0] && free[0]) || (cmd[1] && free[1]))
      idle <= 8'h00;
    else if (idle < 8'(SETTLE))
      idle <= idle + 8'h01;
  end
  // Rest is reported late on purpose, so the stop sequence sees a real slowdown
  assign motion = '{fwd_cmd: cmd[0], rev_cmd: cmd[1], speed_zero: idle == 8'(SETTLE)};
endmodule

// *** tb_top.sv ***
// Self-checking bench for the servo auxiliary loop block.
// Assumes a 4 ns clock, a shortened ms tick and the axis model beside it.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
  localparam int TK = 4; // Short tick keeps gain 3 windows brief
  logic                      aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic                      awready, wready, bvalid, arready, rvalid;
  logic                      servo_on, gain2_cond, dob_active, err_clear, dyn_brake, servo_lock;
  logic                      fwd_lim, rev_lim;
  logic [7:0]                awaddr, araddr;
  logic [31:0]               wdata, rdata, rd;
  logic [1:0]                bresp, rresp, rs, cmd, free;
  logic [2:0]                ctx;
  logic signed [15:0]        tq_in, tq_out;
  servo_aux_pkg::ctrl_mode_e mode;
  servo_aux_pkg::motion_s    motion;
  servo_aux_pkg::gains_s     gain1, gain_out;
  int                        err_count, checked, clears;
  // Device under test and far side
  servo_loop_aux_functions #(.TICK(TK)) servo_loop_aux_functions_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fwd_limit_input(fwd_lim), .rev_limit_input(rev_lim), .ctrl_mode(mode),
    .servo_on(servo_on), .motor_normal(ctx[2]), .autotune_on(ctx[1]), .speed_observer_on(ctx[0]),
    .gain2_cond(gain2_cond), .motion(motion), .gain1(gain1), .torque_in(tq_in), .torque_out(tq_out),
    .gain_out(gain_out), .dob_active(dob_active), .err_clear(err_clear), .dyn_brake(dyn_brake),
    .servo_lock(servo_lock));
  axis_model axis_model_i (.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .free(free),
    .fwd_limit_input(fwd_lim), .rev_limit_input(rev_lim), .motion(motion));
  // Clock, pulse counter and watchdog well past the expected few hundred cycles
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) if (err_clear === 1'b1) clears++;
  initial
  begin
    #200000;
    err_count++;
    results();
  end
  task automatic st(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Register write; address and data are released each on its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  // Register read; data and response are taken at the edge that shows rvalid
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // Reset values, unmapped place and a readback
  task automatic t_regs();
    rdr(servo_aux_pkg::OFF_STATUS);
    `CHK("status", servo_aux_pkg::RST_WORD, rd);
    rdr(8'h28);
    `CHK("unmapped", {servo_aux_pkg::RESP_SLVERR, 32'h0}, {rs, rd});
    wr(servo_aux_pkg::OFF_ISTOP_TL, 32'h14);
    `CHK("bresp", servo_aux_pkg::RESP_OKAY, rs);
    rdr(servo_aux_pkg::OFF_ISTOP_TL);
    `CHK("tl", 32'h14, rd);
  endtask
  // Each stop selection with the forward switch open
  task automatic t_limit();
    for (int s = 0; s < 3; s++)
    begin
      wr(servo_aux_pkg::OFF_CTRL, 32'(s));
      clears = 0;
      // Axis moves freely for one cycle, then runs into the open switch
      @(posedge aclk);
      cmd   <= 2'b01;
      tq_in <= -16'sd50;
      @(posedge aclk);
      free  <= 2'b10;
      st(8);
      `CHK("brake", s == 0, dyn_brake);
      `CHK("decel tq", (s == 2) ? -16'sd20 : 16'sd0, tq_out);
      tq_in <= 16'sd50;
      st(14);
      `CHK("lock", s == 2, servo_lock);
      if (s < 2) `CHK("held tq", 16'sd0, tq_out);
      `CHK("clears", (s == 2) ? 2 : 0, clears);
      rdr(servo_aux_pkg::OFF_STATUS);
      `CHK("fwd blk", 1'b1, rd[servo_aux_pkg::ST_FWD_BLK]);
      @(posedge aclk);
      cmd   <= 2'b10;
      tq_in <= -16'sd50;
      st(4);
      `CHK("rev tq", -16'sd50, tq_out);
      @(posedge aclk);
      free <= 2'b11;
      cmd  <= 2'b00;
      st(8);
    end
  endtask
  // Observer qualification: {mode, servo, normal/autotune/observer, bit2, bit1, gain2, expected}
  task automatic t_dob();
    logic [9:0] dt [11] = '{10'b00_1_100_01_0_1, 10'b01_1_100_01_0_1, 10'b10_1_100_01_0_0,
      10'b00_0_100_01_0_0, 10'b00_1_110_01_0_0, 10'b00_1_101_01_0_0, 10'b00_1_000_01_0_0,
      10'b00_1_100_00_0_0, 10'b00_1_100_11_0_1, 10'b00_1_100_11_1_0, 10'b11_1_100_01_0_0};
    for (int i = 0; i < 11; i++)
    begin
      wr(servo_aux_pkg::OFF_FUNC, {29'h0, dt[i][3:2], 1'b0});
      @(posedge aclk);
      mode       <= servo_aux_pkg::ctrl_mode_e'(dt[i][9:8]);
      servo_on   <= dt[i][7];
      ctx        <= dt[i][6:4];
      gain2_cond <= dt[i][1];
      st(4);
      `CHK("dob", dt[i][0], dob_active);
    end
    @(posedge aclk);
    mode <= servo_aux_pkg::CM_POS;
    {servo_on, ctx, gain2_cond} <= {1'b1, 3'b100, 1'b0};
    st(4 * TK);
  endtask
  // Gain 3 region after commands end, its timeout, gain 2 take-over and ramp back
  task automatic t_gain3();
    wr(servo_aux_pkg::OFF_G3_TIME, 32'h2);
    wr(servo_aux_pkg::OFF_G3_RATIO, 32'hC8);
    wr(servo_aux_pkg::OFF_PG_TIME, 32'h1);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge aclk);
      cmd <= 2'b01;
      st(3);
      cmd <= 2'b00;
      st(3);
      if (k == 0) `CHK("g3", 32'h00C8_0064, gain_out);
      if (k == 0) st(2 * TK + 2);
      if (k == 0) `CHK("g1 back", 32'h0064_0032, gain_out);
      if (k == 1) gain2_cond <= 1'b1;
      if (k == 1) st(3);
      if (k == 1) rdr(servo_aux_pkg::OFF_STATUS);
      if (k == 1) `CHK("g2", 2'h1, rd[servo_aux_pkg::ST_GSEL_LSB +: 2]);
      if (k == 1) gain2_cond <= 1'b0;
      if (k == 1) st(3);
      if (k == 1) `CHK("ramp", 32'h0064_0064, gain_out);
      if (k == 1) wr(servo_aux_pkg::OFF_G3_TIME, 32'h0);
      if (k == 1) wr(servo_aux_pkg::OFF_G3_RATIO, 32'h0);
      if (k == 2) `CHK("no g3", 32'h0064_0032, gain_out);
      st(4 * TK);
    end
  endtask
  // Offsets per mode, servo state and command direction
  task automatic t_offs();
    wr(servo_aux_pkg::OFF_UNBAL, 32'hA);
    wr(servo_aux_pkg::OFF_FWD_FRIC, 32'h3);
    wr(servo_aux_pkg::OFF_REV_FRIC, 32'hFFFB);
    @(posedge aclk);
    tq_in <= 16'sd100;
    cmd   <= 2'b01;
    st(4);
    `CHK("fwd", 16'sd113, tq_out);
    cmd <= 2'b10;
    st(4);
    `CHK("rev", 16'sd105, tq_out);
    mode <= servo_aux_pkg::CM_TORQUE;
    st(4);
    `CHK("torque", 16'sd100, tq_out);
    mode     <= servo_aux_pkg::CM_SPEED;
    servo_on <= 1'b0;
    cmd      <= 2'b00;
    st(4);
    `CHK("spd off", 16'sd110, tq_out);
    mode     <= servo_aux_pkg::CM_POS;
    servo_on <= 1'b1;
    wr(servo_aux_pkg::OFF_UNBAL, 32'h14);
    st(4);
    `CHK("held", 16'sd110, tq_out);
    cmd <= 2'b01;
    st(4);
    `CHK("first cmd", 16'sd123, tq_out);
  endtask
  task automatic results();
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, servo_on, gain2_cond} = '0;
    {awaddr, araddr, wdata, cmd, tq_in, err_count, checked, clears} = '0;
    {free, ctx, gain1} = {2'b11, 3'b100, 32'h0064_0032};
    mode = servo_aux_pkg::CM_POS;
    repeat (6) @(posedge aclk);
    aresetn  <= 1'b1;
    servo_on <= 1'b1;
    t_regs();
    t_limit();
    t_dob();
    t_gain3();
    t_offs();
    results();
  end
endmodule
